/* File: rtl/ecf_map.vh */
// register offsets, field positions, reset values and sizes for the event channel fabric
`ifndef ECF_MAP_VH
`define ECF_MAP_VH

// --------------------------------------------------------------------------
// sizes
// --------------------------------------------------------------------------
`define ECF_NUM_CH 16
`define ECF_NUM_GRP 6
`define ECF_NUM_PUB 8
`define ECF_NUM_SUB 8
`define ECF_IDX_W 8
`define ECF_ADDR_W 12

// --------------------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------------------
`define ECF_GRP_EN_TASK_BASE 12'h000
`define ECF_GRP_DIS_TASK_BASE 12'h004
`define ECF_GRP_EN_SUB_BASE 12'h080
`define ECF_GRP_DIS_SUB_BASE 12'h084
`define ECF_CH_EN_BITS 12'h500
`define ECF_CH_EN_SET 12'h504
`define ECF_CH_EN_CLR 12'h508
`define ECF_GRP_MEMB_BASE 12'h800
`define ECF_PUB_BASE 12'h900
`define ECF_SUB_BASE 12'h980

// --------------------------------------------------------------------------
// fields of a publish or subscribe register
// --------------------------------------------------------------------------
`define ECF_IDX_LSB 0
`define ECF_IDX_MSB 7
`define ECF_EN_BIT 31

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define ECF_CH_EN_RST 16'h0000
`define ECF_MEMB_RST 16'h0000
`define ECF_ROUTE_RST 9'h000

`endif

/* File: rtl/ecf_route_reg.v */
// one publish or subscribe register: channel index plus enable bit
`timescale 1ns/10ps
`default_nettype none
`include "ecf_map.vh"
module ecf_route_reg (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // write port
  input wire wr_en,
  input wire [31:0] wr_data,
  // stored fields
  output wire [`ECF_IDX_W-1:0] channel_index,
  output wire route_en,
  // one-hot channel select, zero while disabled or index out of range
  output wire [`ECF_NUM_CH-1:0] ch_sel
);
  reg [`ECF_IDX_W:0] cfg_reg;

  // cleared at reset so no route is live until software arms it
  always @(posedge clk)
  begin
    if (sys_rst)
      cfg_reg <= `ECF_ROUTE_RST;
    else if (wr_en)
      cfg_reg <= {wr_data[`ECF_EN_BIT], wr_data[`ECF_IDX_MSB:`ECF_IDX_LSB]};
  end

  assign channel_index = cfg_reg[`ECF_IDX_W-1:0];
  assign route_en = cfg_reg[`ECF_IDX_W];

  // decode; an out-of-range index selects nothing
  genvar c;
  generate
    for (c = 0; c < `ECF_NUM_CH; c = c + 1)
    begin : g_sel
      assign ch_sel[c] = route_en && (channel_index == c);
    end
  endgenerate
endmodule // ecf_route_reg
`default_nettype wire

/* File: rtl/ecf_sync3.v */
// three-flop input synchroniser, change accepted when the last two stages agree
`timescale 1ns/10ps
`default_nettype none
module ecf_sync3 (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // raw and filtered level
  input wire async_in,
  output reg sync_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // s1 only feeds s2 so metastability never reaches logic
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        sync_out <= s3_reg;
    end
  end
endmodule // ecf_sync3
`default_nettype wire

/* File: rtl/ecf_top.v */
// event channel fabric: channel config unit, group tasks and peripheral route links
// Function
// R1: route register: channel index and enable; routes only when enabled
// R2: software keeps channel indices in range
// R3: channel fans out to all subscribers; publishers only feed it
// R4: same-cycle events on a channel merge into one pulse
// R5: channel enables: direct, write-one set, write-one clear
// R6: set and clear registers read the channel enables
// R7: six group masks; group tasks set or clear members
// R8: enable tasks at 0x000, disable at 0x004, stride 0x8
// R9: same-cycle enable and disable leave a channel enabled
// R10: group task subscriptions at 0x080 and 0x084, stride 0x8
// R11: membership writes ignored while a group subscription is on
// R12: non-secure peripherals use only non-secure channels
// R13: secure accesses control every channel
// R14: group secure if any member channel is secure
// R15: non-secure access to secure bits: write dropped, read zero
// R16: dropped accesses raise no fault
// R17: non-secure task writes ignored for a secure group
// R18: secure group membership hidden from non-secure access
// R19: non-secure group ignores secure channels
// R20: channel count parameter; one-cycle pulses, passed while enabled
// R21: reset clears enables, memberships and subscriptions
`timescale 1ns/10ps
`default_nettype none
`include "ecf_map.vh"
module ecf_top (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register port
  input wire [`ECF_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_nonsecure,
  output reg [31:0] reg_rdata,
  // security map, from the permission unit (other clock domain)
  input wire [`ECF_NUM_CH-1:0] channel_security_map,
  input wire [`ECF_NUM_PUB-1:0] pub_nonsecure,
  input wire [`ECF_NUM_SUB-1:0] sub_nonsecure,
  // peripheral events and tasks
  input wire [`ECF_NUM_PUB-1:0] periph_event,
  output reg [`ECF_NUM_SUB-1:0] periph_task,
  // channel pulses seen by subscribers
  output reg [`ECF_NUM_CH-1:0] channel_pulse
);
  localparam NCH = `ECF_NUM_CH;
  localparam NG = `ECF_NUM_GRP;
  localparam NP = `ECF_NUM_PUB;
  localparam NS = `ECF_NUM_SUB;

  // --------------------------------------------------------------------------
  // security map synchroniser
  // --------------------------------------------------------------------------
  wire [NCH-1:0] sec_map;
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1)
    begin : g_sec
      ecf_sync3 u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(channel_security_map[i]),
        .sync_out(sec_map[i])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [NCH-1:0] ch_en_reg;
  reg [NCH-1:0] ch_en_next;
  reg [NCH-1:0] memb_reg [0:NG-1];
  reg [NCH-1:0] gen_sub_sel [0:NG-1];
  reg [NCH-1:0] gdis_sub_sel [0:NG-1];
  reg [NG-1:0] gen_sub_en_reg;
  reg [NG-1:0] gdis_sub_en_reg;
  reg [`ECF_IDX_W-1:0] gen_sub_idx_reg [0:NG-1];
  reg [`ECF_IDX_W-1:0] gdis_sub_idx_reg [0:NG-1];

  // access window: only masked bits a non-secure master may touch
  wire [NCH-1:0] acc_mask = reg_nonsecure
    ? ~sec_map : {NCH{1'b1}}; // R13 R15

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire hit_channel_enable_bits = (reg_addr == `ECF_CH_EN_BITS);
  wire hit_set = (reg_addr == `ECF_CH_EN_SET);
  wire hit_clr = (reg_addr == `ECF_CH_EN_CLR);
  wire [`ECF_ADDR_W-1:0] goff = reg_addr - `ECF_GRP_EN_TASK_BASE;
  wire [`ECF_ADDR_W-1:0] soff = reg_addr - `ECF_GRP_EN_SUB_BASE;
  wire [`ECF_ADDR_W-1:0] moff = reg_addr - `ECF_GRP_MEMB_BASE;
  wire [`ECF_ADDR_W-1:0] poff = reg_addr - `ECF_PUB_BASE;
  wire [`ECF_ADDR_W-1:0] uoff = reg_addr - `ECF_SUB_BASE;
  wire in_task = (reg_addr < `ECF_GRP_EN_SUB_BASE) && (goff[11:3] < NG); // R8
  wire in_gsub = (reg_addr >= `ECF_GRP_EN_SUB_BASE) && (soff[11:3] < NG); // R10
  wire in_memb = (reg_addr >= `ECF_GRP_MEMB_BASE) && (moff[1:0] == 2'b00)
    && (moff[11:2] < NG);
  wire in_pub = (reg_addr >= `ECF_PUB_BASE) && (poff[1:0] == 2'b00)
    && (poff[11:2] < NP);
  wire in_sub = (reg_addr >= `ECF_SUB_BASE) && (uoff[1:0] == 2'b00)
    && (uoff[11:2] < NS);
  wire [2:0] grp_ix = in_memb ? moff[4:2]
    : (in_gsub ? soff[5:3] : goff[5:3]);
  wire sub_is_dis = soff[2];
  wire task_is_dis = goff[2];

  // --------------------------------------------------------------------------
  // group security and group task triggers
  // --------------------------------------------------------------------------
  reg [NG-1:0] grp_secure;
  reg [NG-1:0] grp_en_trig;
  reg [NG-1:0] grp_dis_trig;
  reg [NCH-1:0] en_mask;
  reg [NCH-1:0] dis_mask;
  integer g;
  integer gk;
  integer gd;

  // a group turns secure as soon as any member is secure
  always @*
  begin
    en_mask = {NCH{1'b0}};
    dis_mask = {NCH{1'b0}};
    for (g = 0; g < NG; g = g + 1)
    begin
      grp_secure[g] = |(memb_reg[g] & sec_map); // R14
      // register task write, dropped silently for secure group from non-secure master
      grp_en_trig[g] = reg_wr && in_task && !task_is_dis && (grp_ix == g) && reg_wdata[0]
                       && !(reg_nonsecure && grp_secure[g]); // R17 R16
      grp_dis_trig[g] = reg_wr && in_task && task_is_dis && (grp_ix == g) && reg_wdata[0]
                        && !(reg_nonsecure && grp_secure[g]); // R17
      // channel-driven triggers; a non-secure group ignores secure channels
      grp_en_trig[g] = grp_en_trig[g] | (|(gen_sub_sel[g] & channel_pulse
                       & (grp_secure[g] ? {NCH{1'b1}} : ~sec_map))); // R10 R19
      grp_dis_trig[g] = grp_dis_trig[g] | (|(gdis_sub_sel[g] & channel_pulse
                        & (grp_secure[g] ? {NCH{1'b1}} : ~sec_map))); // R19
      if (grp_en_trig[g])
        en_mask = en_mask | memb_reg[g]; // R7
      if (grp_dis_trig[g])
        dis_mask = dis_mask | memb_reg[g]; // R7
    end
  end

  // --------------------------------------------------------------------------
  // channel enable next value
  // --------------------------------------------------------------------------
  // register write first, group tasks after; enable applied last so it wins
  always @*
  begin
    ch_en_next = ch_en_reg;
    if (reg_wr && hit_channel_enable_bits)
      ch_en_next = (ch_en_reg & ~acc_mask)
                   | (reg_wdata[NCH-1:0] & acc_mask); // R5 R15
    if (reg_wr && hit_set)
      ch_en_next = ch_en_next | (reg_wdata[NCH-1:0] & acc_mask); // R5
    if (reg_wr && hit_clr)
      ch_en_next = ch_en_next & ~(reg_wdata[NCH-1:0] & acc_mask); // R5
    ch_en_next = (ch_en_next & ~dis_mask) | en_mask; // R9
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      ch_en_reg <= `ECF_CH_EN_RST; // R21
    else
      ch_en_reg <= ch_en_next;
  end

  // --------------------------------------------------------------------------
  // group membership and group task subscriptions
  // --------------------------------------------------------------------------
  // membership locked while a subscription could fire a task mid-update
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      gen_sub_en_reg <= {NG{1'b0}}; // R21
      gdis_sub_en_reg <= {NG{1'b0}};
      for (gk = 0; gk < NG; gk = gk + 1)
      begin
        memb_reg[gk] <= `ECF_MEMB_RST;
        gen_sub_idx_reg[gk] <= {`ECF_IDX_W{1'b0}};
        gdis_sub_idx_reg[gk] <= {`ECF_IDX_W{1'b0}};
      end
    end
    else
    begin
      for (gk = 0; gk < NG; gk = gk + 1)
      begin
        if (reg_wr && in_memb && (grp_ix == gk) && !gen_sub_en_reg[gk] && !gdis_sub_en_reg[gk]
            && !(reg_nonsecure && grp_secure[gk])) // R11 R18
          memb_reg[gk] <= reg_wdata[NCH-1:0];
        if (reg_wr && in_gsub && (grp_ix == gk)
            && !(reg_nonsecure && grp_secure[gk]))
        begin
          if (sub_is_dis)
          begin
            gdis_sub_en_reg[gk] <= reg_wdata[`ECF_EN_BIT];
            gdis_sub_idx_reg[gk] <= reg_wdata[`ECF_IDX_MSB:`ECF_IDX_LSB];
          end
          else
          begin
            gen_sub_en_reg[gk] <= reg_wdata[`ECF_EN_BIT];
            gen_sub_idx_reg[gk] <= reg_wdata[`ECF_IDX_MSB:`ECF_IDX_LSB];
          end
        end
      end
    end
  end

  // subscription decode to one-hot channel selects
  // full-width compare, so an out-of-range index selects nothing
  integer c;
  always @*
  begin
    for (gd = 0; gd < NG; gd = gd + 1)
    begin
      for (c = 0; c < NCH; c = c + 1)
      begin
        gen_sub_sel[gd][c] = gen_sub_en_reg[gd] && (gen_sub_idx_reg[gd] == c); // R1
        gdis_sub_sel[gd][c] = gdis_sub_en_reg[gd] && (gdis_sub_idx_reg[gd] == c);
      end
    end
  end

  // --------------------------------------------------------------------------
  // peripheral route links
  // --------------------------------------------------------------------------
  wire [NCH-1:0] pub_sel [0:NP-1];
  wire [NCH-1:0] sub_sel [0:NS-1];
  wire [`ECF_IDX_W-1:0] pub_idx [0:NP-1];
  wire [`ECF_IDX_W-1:0] sub_idx [0:NS-1];
  wire [NP-1:0] pub_en;
  wire [NS-1:0] sub_en;

  generate
    for (i = 0; i < NP; i = i + 1)
    begin : g_pub
      ecf_route_reg u_pub (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(reg_wr && in_pub && (poff[11:2] == i)
               && !(reg_nonsecure && !pub_nonsecure[i])),
        .wr_data(reg_wdata),
        .channel_index(pub_idx[i]),
        .route_en(pub_en[i]),
        .ch_sel(pub_sel[i])
      );
    end
    for (i = 0; i < NS; i = i + 1)
    begin : g_sub
      ecf_route_reg u_sub (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(reg_wr && in_sub && (uoff[11:2] == i)
               && !(reg_nonsecure && !sub_nonsecure[i])),
        .wr_data(reg_wdata),
        .channel_index(sub_idx[i]),
        .route_en(sub_en[i]),
        .ch_sel(sub_sel[i])
      );
    end
  endgenerate

  // or-merge of all publishers per channel, gated by channel enable
  reg [NCH-1:0] pulse_next;
  reg [NS-1:0] task_next;
  integer p;
  always @*
  begin
    pulse_next = {NCH{1'b0}};
    for (p = 0; p < NP; p = p + 1)
      if (periph_event[p])
        pulse_next = pulse_next
                     | (pub_sel[p] & (pub_nonsecure[p] ? ~sec_map : {NCH{1'b1}})); // R1 R3 R4 R12
    pulse_next = pulse_next & ch_en_reg; // R20
    for (p = 0; p < NS; p = p + 1)
      task_next[p] = |(sub_sel[p] & channel_pulse
                       & (sub_nonsecure[p] ? ~sec_map : {NCH{1'b1}})); // R3 R12
  end

  // one cycle per hop: event to pulse, pulse to task
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      channel_pulse <= {NCH{1'b0}};
      periph_task <= {NS{1'b0}};
    end
    else
    begin
      channel_pulse <= pulse_next; // R20
      periph_task <= task_next;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  // unmapped and task addresses read zero; no error is flagged
  reg [31:0] rd_next;
  always @*
  begin
    rd_next = 32'h00000000;
    if (hit_channel_enable_bits || hit_set || hit_clr)
      rd_next[NCH-1:0] = ch_en_reg & acc_mask; // R6 R15 R16
    else if (in_memb && !(reg_nonsecure && grp_secure[grp_ix]))
      rd_next[NCH-1:0] = memb_reg[grp_ix]; // R18
    else if (in_gsub && !(reg_nonsecure && grp_secure[grp_ix]))
    begin
      rd_next[`ECF_EN_BIT] = sub_is_dis ? gdis_sub_en_reg[grp_ix]
                             : gen_sub_en_reg[grp_ix];
      rd_next[`ECF_IDX_MSB:`ECF_IDX_LSB] = sub_is_dis ? gdis_sub_idx_reg[grp_ix]
                                           : gen_sub_idx_reg[grp_ix];
    end
    else if (in_pub && !(reg_nonsecure && !pub_nonsecure[poff[4:2]]))
    begin
      rd_next[`ECF_EN_BIT] = pub_en[poff[4:2]];
      rd_next[`ECF_IDX_MSB:`ECF_IDX_LSB] = pub_idx[poff[4:2]];
    end
    else if (in_sub && !(reg_nonsecure && !sub_nonsecure[uoff[4:2]]))
    begin
      rd_next[`ECF_EN_BIT] = sub_en[uoff[4:2]];
      rd_next[`ECF_IDX_MSB:`ECF_IDX_LSB] = sub_idx[uoff[4:2]];
    end
  end

  // cleared after one cycle so stale data never lingers
  always @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 32'h00000000;
  end
endmodule // ecf_top
`default_nettype wire

/* File: verif/ecf_checker.sv */
// port-level assertions for the event channel fabric
`timescale 1ns/10ps
`default_nettype none
`include "ecf_map.vh"
module ecf_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [`ECF_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_nonsecure,
  input wire logic [31:0] reg_rdata,
  // security and event lines
  input wire logic [`ECF_NUM_CH-1:0] channel_security_map,
  input wire logic [`ECF_NUM_PUB-1:0] pub_nonsecure,
  input wire logic [`ECF_NUM_PUB-1:0] periph_event,
  input wire logic [`ECF_NUM_SUB-1:0] periph_task,
  input wire logic [`ECF_NUM_CH-1:0] channel_pulse
);
  // --------
  // helpers
  // --------
  reg [2:0] map_age_reg;
  reg [`ECF_NUM_CH-1:0] map_last_reg;
  reg any_evt_reg;
  reg sec_evt_reg;
  reg any_pulse_reg;
  // the map crosses three flops, so it is trusted only after sitting still
  always @(posedge clk)
  begin
    map_last_reg <= channel_security_map;
    any_evt_reg <= |periph_event;
    sec_evt_reg <= |(periph_event & ~pub_nonsecure);
    any_pulse_reg <= |channel_pulse;
    if (sys_rst || channel_security_map != map_last_reg)
      map_age_reg <= 3'h0;
    else if (map_age_reg != 3'h7)
      map_age_reg <= map_age_reg + 3'h1;
  end
  // --------
  // assertions
  // --------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_reset_quiet: assert property ($fell(sys_rst) |-> {reg_rdata, channel_pulse, periph_task} == '0)
    else $error("outputs busy after reset");
  a_pulse_cause: assert property (|channel_pulse |-> any_evt_reg)
    else $error("channel pulse without event");
  a_task_cause: assert property (|periph_task |-> any_pulse_reg)
    else $error("task without channel pulse");
  a_secure_pulse: assert property (map_age_reg > 3'h5 && |(channel_pulse & channel_security_map) |-> sec_evt_reg)
    else $error("secure channel fed by non-secure event");
  a_ns_hidden: assert property (reg_rd && reg_nonsecure && map_age_reg > 3'h5 && reg_addr == `ECF_CH_EN_BITS
    |=> (reg_rdata[15:0] & $past(channel_security_map)) == 16'h0)
    else $error("secure bit read by non-secure");
  a_set_visible: assert property ((reg_wr && !reg_nonsecure && reg_addr == `ECF_CH_EN_SET) ##1 (reg_rd &&
    !reg_nonsecure && reg_addr == `ECF_CH_EN_BITS) |=> (~reg_rdata & $past(reg_wdata, 2) & 32'h0000FFFF) == 32'h0)
    else $error("set bits not visible");
  a_alias_read: assert property ((reg_rd && !reg_nonsecure && reg_addr == `ECF_CH_EN_BITS) ##1 (reg_rd &&
    !reg_nonsecure && reg_addr == `ECF_CH_EN_SET) |=> reg_rdata == $past(reg_rdata))
    else $error("set read differs");
endmodule // ecf_checker
bind ecf_top ecf_checker i_checker (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_nonsecure(reg_nonsecure), .reg_rdata(reg_rdata),
  .channel_security_map(channel_security_map), .pub_nonsecure(pub_nonsecure),
  .periph_event(periph_event), .periph_task(periph_task), .channel_pulse(channel_pulse));
`default_nettype wire

/* File: verif/ecf_periph_model.sv */
// behavioural peripherals: publishers pulse events, subscribers count tasks
`timescale 1ns/10ps
`default_nettype none
`include "ecf_map.vh"
module ecf_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // event and task lines
  output logic [`ECF_NUM_PUB-1:0] periph_event,
  input wire logic [`ECF_NUM_SUB-1:0] periph_task
);
  int task_cnt [`ECF_NUM_SUB];
  // lines rest low between pulses
  initial periph_event = 8'h00;
  // one event pulse per call, one cycle wide
  task automatic fire(input logic [`ECF_NUM_PUB-1:0] m);
    @(posedge clk);
    periph_event <= m;
    @(posedge clk);
    periph_event <= 8'h00;
  endtask
  // tally task pulses; a stuck line gets counted every cycle
  always @(posedge clk)
    for (int s = 0; s < `ECF_NUM_SUB; s++)
      if (sys_rst)
        task_cnt[s] <= 0;
      else if (periph_task[s] === 1'b1)
        task_cnt[s] <= task_cnt[s] + 1;
endmodule // ecf_periph_model
`default_nettype wire

/* File: verif/ecf_tb_top.sv */
// self-checking testbench for the event channel fabric
`timescale 1ns/10ps
`default_nettype none
`include "ecf_map.vh"
module ecf_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_nonsecure = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [15:0] channel_security_map = 16'h0000;
  logic [7:0] pub_nonsecure = 8'h00;
  logic [7:0] sub_nonsecure = 8'h00;
  logic [7:0] periph_event;
  logic [7:0] periph_task;
  logic [15:0] channel_pulse;
  logic [15:0] en;
  logic [15:0] m;
  logic [7:0] pch [8];
  logic [7:0] sch [8];
  logic pon [8];
  int exp_cnt [8];
  int failures = 0;
  int n_tests = 0;
  // --------
  // clock, design and peripherals
  // --------
  always #2 clk = ~clk;
  ecf_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_nonsecure(reg_nonsecure), .reg_rdata(reg_rdata),
    .channel_security_map(channel_security_map), .pub_nonsecure(pub_nonsecure), .sub_nonsecure(sub_nonsecure),
    .periph_event(periph_event), .periph_task(periph_task), .channel_pulse(channel_pulse));
  ecf_periph_model i_periph (.clk(clk), .sys_rst(sys_rst), .periph_event(periph_event), .periph_task(periph_task));
  // --------
  // bus tasks and checks
  // --------
  function automatic logic [11:0] at(logic [11:0] b, int i, int s);
    return b + 12'(i * s);
  endfunction
  // one bus cycle; strobes stay until the next call lowers them
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d, input logic ns);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    reg_nonsecure <= ns;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns = 1'b0);
    op(1'b1, 1'b0, a, d, ns);
    op(1'b0, 1'b0, a, d, ns);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic ns = 1'b0);
    op(1'b0, 1'b1, a, 32'h0, ns);
    op(1'b0, 1'b0, a, 32'h0, ns);
    #1 chk(reg_rdata, exp);
  endtask
  // subscriber tasks expected from one event mask
  function automatic logic [7:0] exp_tasks(logic [7:0] ev, logic [15:0] channel_enable_bits);
    logic [15:0] hit = 16'h0000;
    logic [7:0] t;
    for (int p = 0; p < 8; p++)
      if (ev[p] && pon[p] && !(pub_nonsecure[p] && channel_security_map[pch[p]]))
        hit[pch[p]] = 1'b1;
    hit = hit & channel_enable_bits;
    for (int s = 0; s < 8; s++)
      t[s] = hit[sch[s]] && !(sub_nonsecure[s] && channel_security_map[sch[s]]);
    return t;
  endfunction
  task automatic route_setup;
    for (int i = 0; i < 8; i++)
    begin
      wr(at(`ECF_PUB_BASE, i, 4), {pon[i], 23'h0, pch[i]});
      wr(at(`ECF_SUB_BASE, i, 4), {1'b1, 23'h0, sch[i]});
    end
  endtask
  task automatic shot(input logic [7:0] ev);
    logic [7:0] t = exp_tasks(ev, en);
    i_periph.fire(ev);
    for (int s = 0; s < 8; s++)
      exp_cnt[s] += int'(t[s]);
  endtask
  task automatic cnt_chk;
    repeat (4) @(posedge clk);
    for (int s = 0; s < 8; s++)
      chk(32'(i_periph.task_cnt[s]), 32'(exp_cnt[s]));
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // --------
  // tests
  // --------
  initial
  begin
    void'($urandom(48810));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(`ECF_CH_EN_BITS, 32'h0);
    for (int g = 0; g < 6; g++)
    begin
      rchk(at(`ECF_GRP_MEMB_BASE, g, 4), 32'h0);
      rchk(at(`ECF_GRP_EN_SUB_BASE, g, 8), 32'h0);
      rchk(at(`ECF_GRP_DIS_SUB_BASE, g, 8), 32'h0);
    end
    tend("reset");
    // direct write, then set and two back-to-back reads
    en = 16'($urandom);
    wr(`ECF_CH_EN_BITS, {16'hFFFF, en});
    rchk(`ECF_CH_EN_BITS, {16'h0, en});
    m = 16'($urandom);
    en = en | m;
    op(1'b1, 1'b0, `ECF_CH_EN_SET, {16'h0, m}, 1'b0);
    op(1'b0, 1'b1, `ECF_CH_EN_BITS, 32'h0, 1'b0);
    op(1'b0, 1'b1, `ECF_CH_EN_SET, 32'h0, 1'b0);
    #1 chk(reg_rdata, {16'h0, en});
    op(1'b0, 1'b0, `ECF_CH_EN_SET, 32'h0, 1'b0);
    #1 chk(reg_rdata, {16'h0, en});
    m = 16'($urandom);
    en = en & ~m;
    wr(`ECF_CH_EN_CLR, {16'h0, m});
    rchk(`ECF_CH_EN_CLR, {16'h0, en});
    tend("enables");
    // two publishers on one channel, publishers 2 to 7 with their enable bit low
    for (int i = 0; i < 8; i++)
    begin
      pch[i] = 8'h03;
      sch[i] = (i < 2) ? 8'h03 : 8'h05;
      pon[i] = i < 2;
    end
    pch[2] = 8'h05;
    route_setup();
    en = 16'h0028;
    wr(`ECF_CH_EN_BITS, 32'h00000028);
    shot(8'h03);
    shot(8'h04);
    en = 16'h0020;
    wr(`ECF_CH_EN_CLR, 32'h00000008);
    shot(8'h01);
    cnt_chk();
    // random routes and enables, indices kept in range
    for (int i = 0; i < 8; i++)
    begin
      pch[i] = 8'($urandom % 16);
      sch[i] = 8'($urandom % 16);
      pon[i] = 1'($urandom);
    end
    route_setup();
    repeat (40)
    begin
      en = 16'($urandom);
      wr(`ECF_CH_EN_BITS, {16'h0, en});
      shot(8'($urandom));
    end
    cnt_chk();
    tend("routing");
    for (int g = 0; g < 6; g++)
    begin
      m = 16'($urandom);
      wr(at(`ECF_GRP_MEMB_BASE, g, 4), {16'h0, m});
      rchk(at(`ECF_GRP_MEMB_BASE, g, 4), {16'h0, m});
      wr(`ECF_CH_EN_BITS, 32'h0);
      wr(at(`ECF_GRP_EN_TASK_BASE, g, 8), 32'h1);
      rchk(`ECF_CH_EN_BITS, {16'h0, m});
      wr(`ECF_CH_EN_BITS, 32'h0000FFFF);
      wr(at(`ECF_GRP_DIS_TASK_BASE, g, 8), 32'h1);
      rchk(`ECF_CH_EN_BITS, {16'h0, ~m});
    end
    // group 0 enable and group 1 disable fired by one channel
    wr(`ECF_GRP_MEMB_BASE, 32'h000000F0);
    wr(at(`ECF_GRP_MEMB_BASE, 1, 4), 32'h00000030);
    pch[0] = 8'h00;
    pon[0] = 1'b1;
    route_setup();
    wr(`ECF_GRP_EN_SUB_BASE, 32'h80000000);
    wr(at(`ECF_GRP_DIS_SUB_BASE, 1, 8), 32'h80000000);
    en = 16'h0001;
    wr(`ECF_CH_EN_BITS, 32'h00000001);
    shot(8'h01);
    rchk(`ECF_CH_EN_BITS, 32'h000000F1);
    wr(at(`ECF_GRP_MEMB_BASE, 1, 4), 32'h0000FFFF);
    rchk(at(`ECF_GRP_MEMB_BASE, 1, 4), 32'h00000030);
    wr(`ECF_GRP_EN_SUB_BASE, 32'h0);
    en = 16'h00F1;
    shot(8'h01);
    rchk(`ECF_CH_EN_BITS, 32'h000000C1);
    wr(at(`ECF_GRP_DIS_SUB_BASE, 1, 8), 32'h0);
    cnt_chk();
    tend("groups");
    // channel 8 secure from here on
    @(posedge clk);
    channel_security_map <= 16'h0100;
    repeat (6) @(posedge clk);
    wr(`ECF_CH_EN_BITS, 32'h00000300);
    rchk(`ECF_CH_EN_BITS, 32'h00000200, 1'b1);
    wr(`ECF_CH_EN_CLR, 32'h00000300, 1'b1);
    rchk(`ECF_CH_EN_SET, 32'h00000100);
    wr(at(`ECF_GRP_MEMB_BASE, 2, 4), 32'h00000100);
    rchk(at(`ECF_GRP_MEMB_BASE, 2, 4), 32'h0, 1'b1);
    wr(at(`ECF_GRP_MEMB_BASE, 2, 4), 32'h0, 1'b1);
    wr(`ECF_CH_EN_CLR, 32'h00000100);
    wr(at(`ECF_GRP_EN_TASK_BASE, 2, 8), 32'h1, 1'b1);
    rchk(`ECF_CH_EN_BITS, 32'h0);
    wr(at(`ECF_GRP_EN_TASK_BASE, 2, 8), 32'h1);
    rchk(`ECF_CH_EN_BITS, 32'h00000100);
    for (int i = 0; i < 8; i++)
    begin
      pch[i] = 8'h08;
      sch[i] = 8'h08;
      pon[i] = i == 3;
    end
    route_setup();
    wr(at(`ECF_GRP_MEMB_BASE, 3, 4), 32'h00000002);
    wr(at(`ECF_GRP_EN_SUB_BASE, 3, 8), 32'h80000008);
    en = 16'h0100;
    @(posedge clk);
    pub_nonsecure <= 8'h08;
    sub_nonsecure <= 8'h01;
    @(posedge clk);
    shot(8'h08);
    @(posedge clk);
    pub_nonsecure <= 8'h00;
    @(posedge clk);
    shot(8'h08);
    cnt_chk();
    rchk(`ECF_CH_EN_BITS, 32'h00000100);
    wr(at(`ECF_GRP_DIS_SUB_BASE, 2, 8), 32'h80000008);
    shot(8'h08);
    rchk(`ECF_CH_EN_BITS, 32'h0);
    tend("security");
    // second reset in mid-run
    wr(`ECF_CH_EN_BITS, 32'h000000FF);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(`ECF_CH_EN_BITS, 32'h0);
    rchk(at(`ECF_GRP_MEMB_BASE, 2, 4), 32'h0);
    tend("rerun reset");
    wrap_up();
  end
  // hang guard, well beyond the test length
  initial
  begin
    #40000;
    failures++;
    wrap_up();
  end
endmodule // ecf_tb_top
`default_nettype wire
